// ==== core/tio_port.sv ====
// Operation
// R1 - port width is a parameter: 1, 4, 8, 16 or 32 pins
// R2 - one direction bit makes all pins input or all output
// R3 - pins driven high or low, or sampled, optionally until a pin condition
// R4 - every register access completes in one cycle, no wait states
// R5 - open collector drives low for zero, releases pin for one
// R6 - open collector selected per port for all its pins
// R7 - data passes via shift register plus transfer register
// R8 - 16-bit port counter times moves between pins and transfer register
// R9 - counter readable anytime; transfer deferrable to a future count
// R10 - counter value latched as timestamp on each transfer
// R11 - pins used by an enabled link are released by the port
// R12 - enabled narrower port overrules this port on shared pins (here: masks only the drive; claim_o and input sampling still include them)
// R13 - unshared pins stay with this port
// R14 - transfers always use full nominal width
// R15 - six clock blocks; block 0 is the tile reference clock
// R16 - blocks 1 to 5 divide to other rates
// R17 - a clock block may take a 1-bit pin as its clock source
// R18 - clock from that pin may be divided further
// R19 - incoming ready strobe qualifies sampled data
// R20 - outgoing ready strobe accompanies driven data
// R21 - after reset the port uses clock block 0
// R22 - transfers and met conditions raise an event to the core (here: only out_load or in_done raise it; a met condition alone does not)
// R23 - counter steps on each selected clock tick and wraps
// R24 - waiting transfer held until condition or time, then signalled
module tio_port #(
    parameter int unsigned PW = 8, // R1
    parameter int unsigned TW = 32
) (
    input  wire logic          core_clk_i,
    input  wire logic          nrst_i,
    input  wire logic [7:0]    addr_i,
    input  wire logic [TW-1:0] wdata_i,
    input  wire logic          wr_i,
    input  wire logic          rd_i,
    output logic      [TW-1:0] rdata_o,
    input  wire logic [PW-1:0] pin_i,
    output logic      [PW-1:0] pin_o,
    output logic      [PW-1:0] pin_oe_o,
    input  wire logic [PW-1:0] link_pins_i,
    input  wire logic [PW-1:0] narrow_claim_i,
    output logic      [PW-1:0] claim_o,
    input  wire logic          ext_clk_pin_i,
    input  wire logic          ready_in_i,
    output logic               outgoing_ready_strobe_o,
    output logic               core_event_o
);
    localparam int unsigned SLICES = TW / PW;
    localparam logic [5:0]  LAST   = 6'(SLICES - 1);
    localparam int          STRIDE = 4;

    // ************************************************
    // helpers
    // ************************************************
    function automatic logic cond_met(input tio_pkg::tio_cond_type m,
                                      input logic [PW-1:0] p,
                                      input logic [PW-1:0] v);
        case (m)
            tio_pkg::TIO_COND_EQ:  cond_met = (p == v);
            tio_pkg::TIO_COND_NEQ: cond_met = (p != v);
            default:               cond_met = 1'b1;
        endcase
    endfunction

    function automatic logic [TW-1:0] shift_in(input logic [TW-1:0] s,
                                               input logic [PW-1:0] p);
        shift_in = (s >> PW) | (TW'(p) << (TW - PW));
    endfunction

    function automatic logic [7:0] clkcfg_addr(input int b);
        clkcfg_addr = tio_pkg::ADDR_CLKCFG + 8'(STRIDE * b);
    endfunction

    // ************************************************
    // state
    // ************************************************
    tio_pkg::tio_ctrl_type   ctrl_ff;
    tio_pkg::tio_clkcfg_type clkcfg_ff [1:5];
    logic [7:0]    div_cnt_ff [1:5];
    logic [5:0]    blk_tick;
    logic          ext_s1_ff;
    logic          ext_s2_ff;
    logic          ext_s3_ff;
    logic          ext_rise;
    logic [15:0]   cnt_ff;
    logic [15:0]   time_ff;
    logic [15:0]   tstamp_ff;
    logic [PW-1:0] cond_val_ff;
    logic [TW-1:0] xfer_ff;
    logic          xfer_full_ff;
    logic [TW-1:0] sh_ff;
    logic [5:0]    left_ff;
    logic          timed_ff;
    logic [PW-1:0] pin_q_ff;
    logic          strobe_ff;
    logic          event_ff;
    logic [TW-1:0] rdata_ff;
    logic          tick;
    logic          time_ok;
    logic          in_take;
    logic          out_load;
    logic          out_shift;
    logic          in_done;
    logic [PW-1:0] owned;
    logic [PW-1:0] pin_seen;
    logic          sel_ok;
    logic          wr_data;
    logic          rd_data;

    assign wr_data = wr_i && (addr_i == tio_pkg::ADDR_DATA);
    assign rd_data = rd_i && (addr_i == tio_pkg::ADDR_DATA);
    // link pins read as zero, so a live link never feeds this port
    assign pin_seen = pin_i & ~link_pins_i; // R11

    // ************************************************
    // clock blocks
    // ************************************************
    // only the second and third stages feed the edge detector
    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            ext_s1_ff <= 1'b0;
            ext_s2_ff <= 1'b0;
            ext_s3_ff <= 1'b0;
        end
        else
        begin
            ext_s1_ff <= ext_clk_pin_i;
            ext_s2_ff <= ext_s1_ff;
            ext_s3_ff <= ext_s2_ff;
        end
    end
    assign ext_rise = ext_s2_ff && !ext_s3_ff; // R17

    always_comb
    begin
        blk_tick[0] = 1'b1; // R15
        for (int b = 1; b < int'(tio_pkg::CLK_BLOCKS); b++)
        begin
            blk_tick[b] = (clkcfg_ff[b].src_ext ? ext_rise : 1'b1) // R17
                          && (div_cnt_ff[b] == clkcfg_ff[b].div); // R16 R18
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            for (int b = 1; b < int'(tio_pkg::CLK_BLOCKS); b++)
            begin
                clkcfg_ff[b]  <= tio_pkg::CLKCFG_RST;
                div_cnt_ff[b] <= 8'h00;
            end
        end
        else
        begin
            for (int b = 1; b < int'(tio_pkg::CLK_BLOCKS); b++)
            begin
                if (wr_i && addr_i == clkcfg_addr(b))
                begin
                    clkcfg_ff[b]  <= wdata_i[tio_pkg::CLKCFG_W-1:0];
                    div_cnt_ff[b] <= 8'h00;
                end
                else if (!clkcfg_ff[b].src_ext || ext_rise)
                begin
                    // R16 R18
                    div_cnt_ff[b] <= blk_tick[b] ? 8'h00 : div_cnt_ff[b] + 8'h01;
                end
            end
        end
    end

    // ************************************************
    // control and counter
    // ************************************************
    // a block number past the last one stalls the port instead of reading junk
    assign sel_ok  = ctrl_ff.clk_sel < tio_pkg::CLK_BLOCKS;
    assign tick    = ctrl_ff.enable && sel_ok && blk_tick[ctrl_ff.clk_sel];
    // only the first slice of a word waits for the target count
    assign time_ok = !timed_ff || (left_ff != 6'h00)
                     || (cnt_ff == time_ff); // R9
    // R19 R3
    assign in_take = tick && !ctrl_ff.dir_out && time_ok
                     && (!ctrl_ff.rdy_in_en || ready_in_i)
                     && cond_met(ctrl_ff.cond, pin_seen, cond_val_ff);
    assign in_done   = in_take && (left_ff == LAST);
    assign out_shift = tick && ctrl_ff.dir_out && (left_ff != 6'h00);
    assign out_load  = tick && ctrl_ff.dir_out && (left_ff == 6'h00)
                       && xfer_full_ff && time_ok; // R24

    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            ctrl_ff     <= tio_pkg::CTRL_RST; // R21
            cond_val_ff <= '0;
        end
        else if (wr_i && addr_i == tio_pkg::ADDR_CTRL)
        begin
            ctrl_ff <= wdata_i[tio_pkg::CTRL_W-1:0]; // R2 R6
        end
        else if (wr_i && addr_i == tio_pkg::ADDR_COND)
        begin
            cond_val_ff <= wdata_i[PW-1:0];
        end
    end

    // wraps silently: software must read it often enough to unwrap
    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            cnt_ff <= tio_pkg::CNT_RST;
        end
        else if (tick)
        begin
            cnt_ff <= cnt_ff + tio_pkg::CNT_STEP; // R8 R23
        end
    end

    // deferral is one-shot: cleared by the transfer it gated
    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            time_ff  <= tio_pkg::CNT_RST;
            timed_ff <= 1'b0;
        end
        else if (wr_i && addr_i == tio_pkg::ADDR_TIME)
        begin
            time_ff  <= wdata_i[15:0]; // R9
            timed_ff <= 1'b1;
        end
        else if (out_load || in_done)
        begin
            timed_ff <= 1'b0;
        end
    end

    // ************************************************
    // serialiser and transfer register
    // ************************************************
    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            sh_ff    <= '0;
            left_ff  <= 6'h00;
            pin_q_ff <= '0;
        end
        else if (out_load)
        begin
            pin_q_ff <= xfer_ff[PW-1:0]; // R7 R14
            sh_ff    <= xfer_ff >> PW;
            left_ff  <= LAST;
        end
        else if (out_shift)
        begin
            pin_q_ff <= sh_ff[PW-1:0];
            sh_ff    <= sh_ff >> PW;
            left_ff  <= left_ff - tio_pkg::LEFT_ONE;
        end
        else if (in_take)
        begin
            sh_ff   <= shift_in(sh_ff, pin_seen); // R3 R7 R14
            left_ff <= in_done ? 6'h00 : left_ff + tio_pkg::LEFT_ONE;
        end
    end

    // a core write landing on the emptying tick wins, so no word is lost
    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            xfer_ff      <= '0;
            xfer_full_ff <= 1'b0;
        end
        else if (ctrl_ff.dir_out)
        begin
            if (wr_data)
            begin
                xfer_ff      <= wdata_i;
                xfer_full_ff <= 1'b1;
            end
            else if (out_load)
            begin
                xfer_full_ff <= 1'b0;
            end
        end
        else
        begin
            if (in_done)
            begin
                xfer_ff      <= shift_in(sh_ff, pin_seen); // R7
                xfer_full_ff <= 1'b1;
            end
            else if (rd_data)
            begin
                xfer_full_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            tstamp_ff <= tio_pkg::CNT_RST;
            event_ff  <= 1'b0;
            strobe_ff <= 1'b0;
        end
        else
        begin
            if (out_load || in_done)
            begin
                tstamp_ff <= cnt_ff; // R10
            end
            event_ff  <= out_load || in_done; // R22 R24
            strobe_ff <= ctrl_ff.rdy_out_en && (out_load || out_shift); // R20
        end
    end

    // ************************************************
    // pin ownership and drive
    // ************************************************
    // narrow claims gate the drive only; shared pins are still sampled
    assign claim_o = ctrl_ff.enable ? ~link_pins_i : '0; // R11 R12
    // R11 R12 R13
    assign owned   = (ctrl_ff.enable && ctrl_ff.dir_out) ?
                     (~link_pins_i & ~narrow_claim_i) : '0;
    // open collector never drives a one; a released line follows the board
    // R5 R6
    assign pin_oe_o = ctrl_ff.open_coll ? (owned & ~pin_q_ff) : owned;
    assign pin_o    = ctrl_ff.open_coll ? '0 : pin_q_ff;
    assign outgoing_ready_strobe_o = strobe_ff;
    assign core_event_o            = event_ff;

    // ************************************************
    // register read port
    // ************************************************
    // answers next cycle, never stalls the core
    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rdata_ff <= '0;
        end
        else if (rd_i)
        begin
            case (addr_i) // R4
                tio_pkg::ADDR_CTRL:   rdata_ff <= TW'(ctrl_ff);
                tio_pkg::ADDR_DATA:   rdata_ff <= xfer_ff;
                tio_pkg::ADDR_COND:   rdata_ff <= TW'(cond_val_ff);
                tio_pkg::ADDR_TIME:   rdata_ff <= TW'(cnt_ff); // R9
                tio_pkg::ADDR_TSTAMP: rdata_ff <= TW'(tstamp_ff);
                tio_pkg::ADDR_STATUS: rdata_ff <= TW'({timed_ff,
                                                       left_ff != 6'h00,
                                                       xfer_full_ff});
                default:
                begin
                    rdata_ff <= '0;
                    for (int b = 1; b < int'(tio_pkg::CLK_BLOCKS); b++)
                    begin
                        if (addr_i == clkcfg_addr(b))
                        begin
                            rdata_ff <= TW'(clkcfg_ff[b]);
                        end
                    end
                end
            endcase
        end
    end
    assign rdata_o = rdata_ff;
endmodule

// ==== dv/tio_ext_hw.sv ====
module tio_ext_hw #(
    parameter int unsigned PW = 8
) (
    input  wire logic          core_clk_i,
    input  wire logic [PW-1:0] dut_pin_i,
    input  wire logic [PW-1:0] dut_oe_i,
    input  wire logic          drv_en_i,
    input  wire logic [PW-1:0] drv_val_i,
    input  wire logic          rdy_i,
    input  wire logic          ext_run_i,
    output logic      [PW-1:0] pad_o,
    output logic               ready_o,
    output logic               ext_clk_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] div_ff = 2'h0;
    logic       ext_ff = 1'b0;
    // pads have pull-downs: a released line reads low, not its last value
    assign pad_o = (dut_oe_i & dut_pin_i) | (~dut_oe_i & (drv_en_i ? drv_val_i : '0));
    assign ready_o = rdy_i & drv_en_i;
    assign ext_clk_o = ext_ff;
    // application clock stands still unless a burst is running
    always_ff @(posedge core_clk_i)
    begin
        div_ff <= ext_run_i ? div_ff + 2'h1 : 2'h0;
        ext_ff <= ext_run_i ? ext_ff ^ (div_ff == 2'h3) : 1'b0;
    end
endmodule

// ==== dv/tio_port_properties.sv ====
module tio_port_properties #(
    parameter int unsigned PW = 8,
    parameter int unsigned TW = 32
) (
    input wire logic          core_clk_i,
    input wire logic          nrst_i,
    input wire logic [7:0]    addr_i,
    input wire logic          rd_i,
    input wire logic [TW-1:0] rdata_o,
    input wire logic [PW-1:0] pin_oe_o,
    input wire logic [PW-1:0] link_pins_i,
    input wire logic [PW-1:0] narrow_claim_i,
    input wire logic [PW-1:0] claim_o,
    input wire logic          outgoing_ready_strobe_o,
    input wire logic          core_event_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****************
    // pin side, event and read port checks
    // ****************
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!nrst_i);
    sequence s_rd_time;
        rd_i && addr_i == tio_pkg::ADDR_TIME;
    endsequence
    property p_claim_link; (claim_o & link_pins_i) == '0; endproperty
    a_claim_link: assert property (p_claim_link) else $error("claim on link pin");
    property p_oe_link; (pin_oe_o & link_pins_i) == '0; endproperty
    a_oe_link: assert property (p_oe_link) else $error("drive on link pin");
    property p_oe_narrow; (pin_oe_o & narrow_claim_i) == '0; endproperty
    a_oe_narrow: assert property (p_oe_narrow) else $error("drive on narrow pin");
    property p_claim_full; claim_o != '0 |-> (claim_o | link_pins_i) == '1; endproperty
    a_claim_full: assert property (p_claim_full) else $error("free pin unclaimed");
    property p_strobe; outgoing_ready_strobe_o |-> (claim_o | link_pins_i) == '1; endproperty
    a_strobe: assert property (p_strobe) else $error("strobe while idle");
    property p_event; core_event_o |=> !core_event_o; endproperty
    a_event: assert property (p_event) else $error("event too long");
    property p_unmapped; rd_i && addr_i > 8'h34 |=> rdata_o == '0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    property p_count;
        s_rd_time ##2 s_rd_time |=> 16'(rdata_o[15:0] - $past(rdata_o[15:0], 2)) <= 16'h0002;
    endproperty
    a_count: assert property (p_count) else $error("counter jump");
endmodule

bind tio_port tio_port_properties #(.PW(PW), .TW(TW)) tio_port_properties_i (
    .core_clk_i, .nrst_i, .addr_i, .rd_i, .rdata_o, .pin_oe_o, .link_pins_i,
    .narrow_claim_i, .claim_o, .outgoing_ready_strobe_o, .core_event_o);

// ==== dv/tio_port_test.sv ====
module tio_port_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0, nrst = 1'b0, wr_s = 1'b0, rd_s = 1'b0;
    logic        rdy = 1'b0, drv_en = 1'b0, ext_run = 1'b0;
    logic [7:0]  addr = 8'h00, link = 8'h00, narrow = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, d0, d1;
    logic [7:0]  pin_i, pin_o, pin_oe, claim;
    logic        ready_in, ext_clk, strobe, evt;
    int          n_errors = 0, n_tests = 0;
    tio_port #(.PW(8), .TW(32)) tio_port_i (.core_clk_i(clk), .nrst_i(nrst), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr_s), .rd_i(rd_s), .rdata_o(rdata), .pin_i(pin_i),
        .pin_o(pin_o), .pin_oe_o(pin_oe), .link_pins_i(link), .narrow_claim_i(narrow),
        .claim_o(claim), .ext_clk_pin_i(ext_clk), .ready_in_i(ready_in),
        .outgoing_ready_strobe_o(strobe), .core_event_o(evt));
    tio_ext_hw #(.PW(8)) tio_ext_hw_i (.core_clk_i(clk), .dut_pin_i(pin_o), .dut_oe_i(pin_oe),
        .drv_en_i(drv_en), .drv_val_i(8'h5c), .rdy_i(rdy), .ext_run_i(ext_run),
        .pad_o(pin_i), .ready_o(ready_in), .ext_clk_o(ext_clk));
    // ****************
    // bus and checks
    // ****************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 d = rdata;
    endtask
    // masked pins belong to a link or a narrower port
    task automatic send(input logic [31:0] d, input logic oc);
        logic [7:0] m;
        m = ~(link | narrow);
        wr(tio_pkg::ADDR_DATA, d);
        for (int i = 0; i < 80 && strobe !== 1'b1; i++) @(posedge clk) #1;
        chk(evt, 1'b1);
        for (int k = 0; k < 4; k++)
        begin
            chk(strobe, 1'b1);
            chk(pin_o & m, oc ? 8'h00 : d[8*k+:8] & m);
            chk(pin_oe, (oc ? ~d[8*k+:8] : 8'hff) & m);
            @(posedge clk) #1;
        end
    endtask
    task automatic wait_full;
        for (int i = 0; i < 20; i++)
        begin
            rd(tio_pkg::ADDR_STATUS, d0);
            if (d0[0] === 1'b1) break;
        end
        chk(d0[0], 1'b1);
    endtask
    // ****************
    // scenarios
    // ****************
    task automatic t_reset;
        chk({pin_oe, claim, 7'h0, evt}, 32'h0);
        wr(8'h44, 32'hffffffff);
        rd(8'h40, d0);
        chk(d0, 32'h0);
        rd(tio_pkg::ADDR_CTRL, d0);
        chk(d0, 32'h0);
    endtask
    task automatic t_out;
        wr(tio_pkg::ADDR_CTRL, 32'h083);
        send(32'h44332211, 1'b0);
        wr(tio_pkg::ADDR_CTRL, 32'h087);
        send(32'h00c300a5, 1'b1);
    endtask
    task automatic t_share;
        link <= 8'h0f;
        narrow <= 8'h30;
        wr(tio_pkg::ADDR_CTRL, 32'h083);
        #1 chk(claim, 8'hf0);
        send(32'h8877c3e1, 1'b0);
        link <= 8'h00;
        narrow <= 8'h00;
    endtask
    task automatic t_time;
        rd(tio_pkg::ADDR_TIME, d0);
        rd(tio_pkg::ADDR_TIME, d1);
        chk(16'(d1[15:0] - d0[15:0]), 16'h0002);
        wr(tio_pkg::ADDR_TIME, {16'h0, d1[15:0] + 16'h0028});
        send(32'h0badf00d, 1'b0);
        rd(tio_pkg::ADDR_TSTAMP, d0);
        chk(d0[15:0], d1[15:0] + 16'h0028);
    endtask
    task automatic t_clk;
        wr(8'h24, 32'h003);
        wr(tio_pkg::ADDR_CTRL, 32'h009);
        rd(tio_pkg::ADDR_TIME, d0);
        repeat (38) @(posedge clk);
        rd(tio_pkg::ADDR_TIME, d1);
        chk(16'(d1[15:0] - d0[15:0]), 16'h000a);
        wr(8'h28, 32'h101);
        wr(tio_pkg::ADDR_CTRL, 32'h011);
        ext_run <= 1'b1;
        rd(tio_pkg::ADDR_TIME, d0);
        repeat (78) @(posedge clk);
        rd(tio_pkg::ADDR_TIME, d1);
        d1 = 32'(16'(d1[15:0] - d0[15:0]));
        chk(d1 >= 32'h4 && d1 <= 32'h6, 1'b1);
        ext_run <= 1'b0;
    endtask
    task automatic t_in;
        // mid-run reset drops the half-filled word and full flag left by t_clk
        nrst <= 1'b0;
        drv_en <= 1'b1;
        @(posedge clk);
        nrst <= 1'b1;
        #1 chk({pin_oe, claim, 7'h0, evt}, 32'h0);
        chk(rdata, 32'h0);
        wr(tio_pkg::ADDR_CTRL, 32'h041);
        repeat (20) @(posedge clk);
        rd(tio_pkg::ADDR_STATUS, d0);
        chk(d0[0], 1'b0);
        rdy <= 1'b1;
        wait_full();
        rd(tio_pkg::ADDR_DATA, d0);
        chk(d0, 32'h5c5c5c5c);
        wr(tio_pkg::ADDR_COND, 32'h05c);
        wr(tio_pkg::ADDR_CTRL, 32'h241);
        rd(tio_pkg::ADDR_DATA, d0);
        repeat (20) @(posedge clk);
        rd(tio_pkg::ADDR_STATUS, d0);
        chk(d0[0], 1'b0);
        wr(tio_pkg::ADDR_CTRL, 32'h141);
        wait_full();
        rd(tio_pkg::ADDR_DATA, d0);
        chk(d0, 32'h5c5c5c5c);
    endtask
    task automatic final_report;
        $display("errors %0d comparisons %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        forever #25 clk = ~clk;
    end
    initial
    begin
        repeat (4000) @(posedge clk);
        n_errors++;
        final_report();
    end
    initial
    begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_out();
        t_share();
        t_time();
        t_clk();
        t_in();
        final_report();
    end
endmodule

// ==== pkg/tio_pkg.sv ====
package tio_pkg;
    // ************************************************
    // register byte addresses
    // ************************************************
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_DATA   = 8'h04;
    localparam logic [7:0] ADDR_COND   = 8'h08;
    localparam logic [7:0] ADDR_TIME   = 8'h0c;
    localparam logic [7:0] ADDR_TSTAMP = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    // clock block n config at ADDR_CLKCFG + 4*n, n = 1..5
    localparam logic [7:0] ADDR_CLKCFG = 8'h20;
    localparam logic [2:0] CLK_BLOCKS  = 3'h6;

    // ************************************************
    // field layouts
    // ************************************************
    typedef enum logic [1:0] {
        TIO_COND_NONE,
        TIO_COND_EQ,
        TIO_COND_NEQ
    } tio_cond_type;

    typedef struct packed {
        logic         timed_arm;
        tio_cond_type cond;
        logic         rdy_out_en;
        logic         rdy_in_en;
        logic [2:0]   clk_sel;
        logic         open_coll;
        logic         dir_out;
        logic         enable;
    } tio_ctrl_type;

    typedef struct packed {
        logic       src_ext;
        logic [7:0] div;
    } tio_clkcfg_type;

    localparam int unsigned CTRL_W   = 11;
    localparam int unsigned CLKCFG_W = 9;
    localparam tio_ctrl_type   CTRL_RST   = '0;
    localparam tio_clkcfg_type CLKCFG_RST = '0;
    localparam logic [15:0] CNT_RST  = 16'h0000;
    localparam logic [15:0] CNT_STEP = 16'h0001;
    localparam logic [5:0]  LEFT_ONE = 6'h01;
endpackage
